/* core/threshold_alert_regs.sv */
// Purpose: Alert limit registers, limit comparison and serial overlay.
// Assumes: Readings come from logic on the same clock; one-cycle strobes.
// Notes: Alert pin is open drain and only ever pulls low.
//
// Function
// - Limit word: upper byte maximum, lower byte minimum.
// - Alert when voltage exceeds upper limit.
// - Alert when voltage falls below lower limit.
// - Thermal limits reset disabled, signed, one-degree steps.
// - Alert when temperature exceeds upper limit.
// - Alert when temperature falls below lower limit.
// - Charge limits reset disabled, one-percent steps.
// - Alert when charge exceeds upper limit.
// - Alert when charge falls below lower limit.
// - Current limits reset disabled, 80 mA steps.
// - Alert when current exceeds upper limit.
// - Alert when current falls below lower limit.
// - Both enables clear: serial replaces output words.
// - Serial words at fixed addresses; else normal outputs.
// - Map covers pages zero to four, B, D.
// - Voltage limits reset disabled, 20 mV steps.
// - Alert pin driven only while alert enabled.
// - Alerts sticky or self-clearing by configuration.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module threshold_alert_regs #(
  parameter logic [127:0] SERIAL_NUMBER = threshold_alert_pkg::DEFAULT_SERIAL
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Measurement readings.
  input wire logic [15:0] cell_voltage_reading,
  input wire logic [15:0] thermal_reading,
  input wire logic [15:0] reported_charge_percent,
  input wire logic [15:0] current_reading,
  // Normal output words behind the overlay, word 0 in the low bits.
  input wire logic [127:0] normal_output_words,
  // Open-drain alert pin.
  output logic alert_output_out,
  output logic alert_output_oe_n,
  // Configuration seen by the gauge logic.
  output logic rate_estimate_enable,
  output logic dynamic_power_enable
);
  import threshold_alert_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] voltage_alert_limits;
    logic [15:0] thermal_alert_limits;
    logic [15:0] charge_alert_limits;
    logic [15:0] current_alert_limits;
    logic [15:0] alert_control;
    logic [15:0] secondary_config;
    logic [FLAG_COUNT-1:0] alert_flags;
    logic [15:0] rdata;
    logic alert_oe_n;
    logic alert_level;
  } state_t;

  state_t state;
  state_t next_state;

  logic [FLAG_COUNT-1:0] violation;
  logic [FLAG_COUNT-1:0] flag_clear;
  logic overlay_active;
  logic page_valid;
  logic [SERIAL_WORDS-1:0] overlay_hit;
  logic [15:0] overlay_word [SERIAL_WORDS];
  logic [16:0] current_wide;
  logic [16:0] current_upper_scaled;
  logic [16:0] current_lower_scaled;
  logic [7:0] voltage_upper_limit;
  logic [7:0] voltage_lower_limit;
  logic [7:0] thermal_upper_limit;
  logic [7:0] thermal_lower_limit;
  logic [7:0] charge_upper_limit;
  logic [7:0] charge_lower_limit;
  logic [7:0] current_upper_limit;
  logic [7:0] current_lower_limit;

  // ---------------------------------------------------------------
  // Limit fields and comparisons
  // ---------------------------------------------------------------
  // Each limit word splits into a maximum byte and a minimum byte.
  assign voltage_upper_limit = state.voltage_alert_limits[15:8];
  assign voltage_lower_limit = state.voltage_alert_limits[7:0];
  assign thermal_upper_limit = state.thermal_alert_limits[15:8];
  assign thermal_lower_limit = state.thermal_alert_limits[7:0];
  assign charge_upper_limit = state.charge_alert_limits[15:8];
  assign charge_lower_limit = state.charge_alert_limits[7:0];
  assign current_upper_limit = state.current_alert_limits[15:8];
  assign current_lower_limit = state.current_alert_limits[7:0];

  // Current limits are scaled up rather than the reading truncated, so that
  // a reading between steps still compares exactly.
  assign current_wide = {current_reading[15], current_reading};
  assign current_upper_scaled = {current_upper_limit, 9'h000};
  assign current_lower_scaled = {current_lower_limit, 9'h000};

  // Voltage and charge use the whole-step upper byte unsigned; temperature
  // is signed whole degrees; current is signed with 512 counts a step.
  always_comb begin
    violation = '0;
    violation[FLAG_VOLT_HIGH] = cell_voltage_reading[15:8] > voltage_upper_limit;
    violation[FLAG_VOLT_LOW] = cell_voltage_reading[15:8] < voltage_lower_limit;
    violation[FLAG_TEMP_HIGH] =
      $signed(thermal_reading[15:8]) > $signed(thermal_upper_limit);
    violation[FLAG_TEMP_LOW] =
      $signed(thermal_reading[15:8]) < $signed(thermal_lower_limit);
    violation[FLAG_CHARGE_HIGH] = reported_charge_percent[15:8] > charge_upper_limit;
    violation[FLAG_CHARGE_LOW] = reported_charge_percent[15:8] < charge_lower_limit;
    violation[FLAG_CURRENT_HIGH] =
      $signed(current_wide) > $signed(current_upper_scaled);
    violation[FLAG_CURRENT_LOW] =
      $signed(current_wide) < $signed(current_lower_scaled);
  end

  // ---------------------------------------------------------------
  // Serial overlay and page decode
  // ---------------------------------------------------------------
  // The serial number is only visible while both enables are clear.
  assign overlay_active = !state.secondary_config[RATE_ESTIMATE_ENABLE_BIT] &&
                          !state.secondary_config[DYNAMIC_POWER_ENABLE_BIT];

  // Only pages zero to four, B and D hold registers.
  assign page_valid = (reg_addr[7:4] <= PAGE_LAST_LOW) || (reg_addr[7:4] == PAGE_B) ||
                      (reg_addr[7:4] == PAGE_D);

  // One overlay slot per serial word.
  genvar gi;
  generate
    for (gi = 0; gi < SERIAL_WORDS; gi++) begin : g_overlay
      assign overlay_hit[gi] = reg_addr == SERIAL_ADDR[gi];
      assign overlay_word[gi] = overlay_active ?
        SERIAL_NUMBER[16*gi +: 16] : normal_output_words[16*gi +: 16];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Writes land on the addressed limit or configuration word or clear sticky status flags; reads capture
  // the addressed word for the following cycle; anything unmapped reads zero.
  always_comb begin
    next_state = state;
    flag_clear = '0;
    if (reg_write && page_valid) begin
      case (reg_addr)
        ADDR_VOLTAGE_LIMITS: next_state.voltage_alert_limits = reg_wdata;
        ADDR_THERMAL_LIMITS: next_state.thermal_alert_limits = reg_wdata;
        ADDR_CHARGE_LIMITS: next_state.charge_alert_limits = reg_wdata;
        ADDR_CURRENT_LIMITS: next_state.current_alert_limits = reg_wdata;
        ADDR_ALERT_CONTROL: next_state.alert_control = reg_wdata;
        ADDR_SECONDARY_CONFIG: next_state.secondary_config = reg_wdata;
        ADDR_ALERT_STATUS: flag_clear = reg_wdata[FLAG_COUNT-1:0];
        default: next_state = state;
      endcase
    end
    // Sticky mode holds a flag until software clears it, and a violation
    // in the clearing cycle wins; otherwise flags follow the violation.
    if (state.alert_control[ALERT_STICKY_BIT]) begin
      next_state.alert_flags = (state.alert_flags & ~flag_clear) | violation;
    end else begin
      next_state.alert_flags = violation;
    end
    // The pin pulls low only while alerts are enabled.
    next_state.alert_oe_n = !(state.alert_control[ALERT_ENABLE_BIT] &&
                              (|state.alert_flags));
    next_state.alert_level = 1'b0;
    next_state.rdata = 16'h0000;
    if (reg_read && page_valid) begin
      case (reg_addr)
        ADDR_ALERT_STATUS: next_state.rdata = {8'h00, state.alert_flags};
        ADDR_VOLTAGE_LIMITS: next_state.rdata = state.voltage_alert_limits;
        ADDR_THERMAL_LIMITS: next_state.rdata = state.thermal_alert_limits;
        ADDR_CHARGE_LIMITS: next_state.rdata = state.charge_alert_limits;
        ADDR_CURRENT_LIMITS: next_state.rdata = state.current_alert_limits;
        ADDR_ALERT_CONTROL: next_state.rdata = state.alert_control;
        ADDR_SECONDARY_CONFIG: next_state.rdata = state.secondary_config;
        default: begin
          for (int i = 0; i < SERIAL_WORDS; i++) begin
            if (overlay_hit[i]) begin
              next_state.rdata = overlay_word[i];
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Limits come out of reset at values no reading can violate.
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
      state.voltage_alert_limits <= RESET_VOLTAGE_LIMITS;
      state.thermal_alert_limits <= RESET_THERMAL_LIMITS;
      state.charge_alert_limits <= RESET_CHARGE_LIMITS;
      state.current_alert_limits <= RESET_CURRENT_LIMITS;
      state.alert_control <= RESET_ALERT_CONTROL;
      state.secondary_config <= RESET_SECONDARY_CONFIG;
      state.alert_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign alert_output_out = state.alert_level;
  assign alert_output_oe_n = state.alert_oe_n;
  assign rate_estimate_enable = state.secondary_config[RATE_ESTIMATE_ENABLE_BIT];
  assign dynamic_power_enable = state.secondary_config[DYNAMIC_POWER_ENABLE_BIT];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_limit_readback: assert property (@(posedge clock) disable iff (srst)
    reg_read && reg_addr == ADDR_VOLTAGE_LIMITS |=>
      reg_rdata == $past(state.voltage_alert_limits))
    else $error("Voltage limit read back wrong.");

  chk_reset_limits: assert property (@(posedge clock)
    srst |=> state.thermal_alert_limits == 16'h7f80 &&
      state.current_alert_limits == 16'h7f80 &&
      state.voltage_alert_limits == 16'hff00 && state.charge_alert_limits == 16'hff00)
    else $error("Limit reset value wrong.");

  chk_volt_high_flag: assert property (@(posedge clock) disable iff (srst)
    cell_voltage_reading[15:8] > state.voltage_alert_limits[15:8] |=>
      state.alert_flags[FLAG_VOLT_HIGH])
    else $error("Overvoltage not flagged.");

  chk_temp_low_flag: assert property (@(posedge clock) disable iff (srst)
    $signed(thermal_reading[15:8]) < $signed(state.thermal_alert_limits[7:0]) |=>
      state.alert_flags[FLAG_TEMP_LOW])
    else $error("Undertemperature not flagged.");

  chk_charge_flags: assert property (@(posedge clock) disable iff (srst)
    (reported_charge_percent[15:8] > state.charge_alert_limits[15:8] ||
     reported_charge_percent[15:8] < state.charge_alert_limits[7:0]) |=>
      (state.alert_flags[FLAG_CHARGE_HIGH] || state.alert_flags[FLAG_CHARGE_LOW]))
    else $error("Charge violation not flagged.");

  chk_current_flags: assert property (@(posedge clock) disable iff (srst)
    $signed({current_reading[15], current_reading}) >
      $signed({state.current_alert_limits[15:8], 9'h000}) |=>
      state.alert_flags[FLAG_CURRENT_HIGH])
    else $error("Overcurrent not flagged.");

  chk_disabled_quiet: assert property (@(posedge clock) disable iff (srst)
    state.voltage_alert_limits == 16'hff00 && state.thermal_alert_limits == 16'h7f80 &&
    state.charge_alert_limits == 16'hff00 && state.current_alert_limits == 16'h7f80 |->
      violation == '0)
    else $error("Disabled limit tripped.");

  chk_alert_gate: assert property (@(posedge clock) disable iff (srst)
    !state.alert_control[ALERT_ENABLE_BIT] |=> alert_output_oe_n)
    else $error("Alert driven while disabled.");

  chk_alert_drive: assert property (@(posedge clock) disable iff (srst)
    state.alert_control[ALERT_ENABLE_BIT] && (|state.alert_flags) |=>
      !alert_output_oe_n && !alert_output_out)
    else $error("Alert not driven low.");

  chk_auto_clear: assert property (@(posedge clock) disable iff (srst)
    !state.alert_control[ALERT_STICKY_BIT] && violation == '0 |=> state.alert_flags == '0)
    else $error("Flags did not clear.");

  chk_sticky_hold: assert property (@(posedge clock) disable iff (srst)
    state.alert_control[ALERT_STICKY_BIT] && (|state.alert_flags) &&
    !(reg_write && reg_addr == ADDR_ALERT_STATUS) |=>
      (state.alert_flags & $past(state.alert_flags)) == $past(state.alert_flags))
    else $error("Sticky flag lost.");

  chk_serial_overlay: assert property (@(posedge clock) disable iff (srst)
    reg_read && reg_addr == 8'hd4 && overlay_active |=> reg_rdata == SERIAL_NUMBER[15:0])
    else $error("Serial word 0 wrong.");

  chk_normal_words: assert property (@(posedge clock) disable iff (srst)
    reg_read && reg_addr == 8'hdf && !overlay_active |=>
      reg_rdata == $past(normal_output_words[127:112]))
    else $error("Normal output word wrong.");

  chk_page_decode: assert property (@(posedge clock) disable iff (srst)
    reg_read && !(reg_addr[7:4] <= 4'h4 || reg_addr[7:4] == 4'hb ||
      reg_addr[7:4] == 4'hd) |=> reg_rdata == 16'h0000)
    else $error("Unmapped page read nonzero.");

endmodule : threshold_alert_regs

/* core/threshold_alert_pkg.sv */
// Purpose: Shared constants for the threshold alert register bank.
// Assumes: Word-addressed register port, 8-bit address, 16-bit data.
// Notes: Page is the upper address nibble, word index the lower one.
package threshold_alert_pkg;

  // ---------------------------------------------------------------
  // Register offsets (word addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ALERT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_VOLTAGE_LIMITS = 8'h01;
  localparam logic [7:0] ADDR_THERMAL_LIMITS = 8'h02;
  localparam logic [7:0] ADDR_CHARGE_LIMITS = 8'h03;
  localparam logic [7:0] ADDR_ALERT_CONTROL = 8'h1d;
  localparam logic [7:0] ADDR_CURRENT_LIMITS = 8'hb4;
  localparam logic [7:0] ADDR_SECONDARY_CONFIG = 8'hbb;

  // Serial words 0 to 7 in order.
  localparam logic [0:7][7:0] SERIAL_ADDR = '{8'hd4, 8'hd5, 8'hd9, 8'hda,
                                             8'hdc, 8'hdd, 8'hde, 8'hdf};
  localparam int SERIAL_WORDS = 8;

  // Occupied pages.
  localparam logic [3:0] PAGE_LAST_LOW = 4'h4;
  localparam logic [3:0] PAGE_B = 4'hb;
  localparam logic [3:0] PAGE_D = 4'hd;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RESET_VOLTAGE_LIMITS = 16'hff00;
  localparam logic [15:0] RESET_THERMAL_LIMITS = 16'h7f80;
  localparam logic [15:0] RESET_CHARGE_LIMITS = 16'hff00;
  localparam logic [15:0] RESET_CURRENT_LIMITS = 16'h7f80;
  localparam logic [15:0] RESET_ALERT_CONTROL = 16'h0000;
  localparam logic [15:0] RESET_SECONDARY_CONFIG = 16'h3000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ALERT_ENABLE_BIT = 2;
  localparam int ALERT_STICKY_BIT = 11;
  localparam int DYNAMIC_POWER_ENABLE_BIT = 12;
  localparam int RATE_ESTIMATE_ENABLE_BIT = 13;
  // Current limit step is 512 reading counts.
  localparam int CURRENT_LIMIT_SHIFT = 9;

  // Violation flag positions in the status word.
  localparam int FLAG_VOLT_LOW = 0;
  localparam int FLAG_VOLT_HIGH = 1;
  localparam int FLAG_TEMP_LOW = 2;
  localparam int FLAG_TEMP_HIGH = 3;
  localparam int FLAG_CHARGE_LOW = 4;
  localparam int FLAG_CHARGE_HIGH = 5;
  localparam int FLAG_CURRENT_LOW = 6;
  localparam int FLAG_CURRENT_HIGH = 7;
  localparam int FLAG_COUNT = 8;

  // Arbitrary serial number used as a default only.
  localparam logic [127:0] DEFAULT_SERIAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

endpackage : threshold_alert_pkg

/* test/threshold_alert_regs_test.sv */
// Purpose: Self-checking bench for the threshold alert register bank.
// Assumes: Reads return data one cycle after the strobe, zero otherwise.
// Notes: Reads note their expected word in a queue; a watcher compares.
`timescale 1ns/100ps
module threshold_alert_regs_test;
  import threshold_alert_pkg::*;

  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  // Arbitrary serial value, distinct from the package default.
  localparam logic [127:0] SER = 128'h1357_9bdf_2468_ace0_0f1e_2d3c_4b5a_6978;
  logic clock, srst, reg_write, reg_read, pend;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] cell_voltage_reading, thermal_reading, reported_charge_percent, current_reading;
  logic [127:0] normal_output_words;
  logic alert_output_out, alert_output_oe_n, rate_estimate_enable, dynamic_power_enable;
  logic [15:0] exp_q[$];
  logic [7:0] adr_q[$];
  logic [7:0] lim_adr[4], up[4], lo[4];
  logic [15:0] mid[4], rv[4];
  int errors, n_compared, cycles, seed;

  threshold_alert_regs #(.SERIAL_NUMBER(SER)) dut_u (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cell_voltage_reading(cell_voltage_reading), .thermal_reading(thermal_reading),
    .reported_charge_percent(reported_charge_percent), .current_reading(current_reading),
    .normal_output_words(normal_output_words), .alert_output_out(alert_output_out),
    .alert_output_oe_n(alert_output_oe_n), .rate_estimate_enable(rate_estimate_enable),
    .dynamic_power_enable(dynamic_power_enable)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task finish_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // One bus cycle; every strobe is rewritten so a cycle never repeats by accident.
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : bus

  task wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  task idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask : idle

  // Readings change with the strobes dropped, so no stray access repeats.
  task set_rd(input logic [15:0] v, input logic [15:0] t, input logic [15:0] s,
              input logic [15:0] i);
    bus(1'b0, 1'b0, 8'h00, 16'h0000);
    cell_voltage_reading <= v;
    thermal_reading <= t;
    reported_charge_percent <= s;
    current_reading <= i;
  endtask : set_rd

  // Settled outputs are looked at away from the launching edge.
  task pin(input logic e);
    @(negedge clock);
    check("alert pin enable", {15'h0000, e}, {15'h0000, alert_output_oe_n});
    check("alert pin level", 16'h0000, {15'h0000, alert_output_out});
  endtask : pin

  // ---------------------------------------------------------------
  // Clock, watcher and timeout
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) pend <= reg_read & ~srst;

  // Read data must appear only in the cycle after a strobe, zero elsewhere.
  always @(negedge clock) begin
    if (pend === 1'b1 && exp_q.size() > 0) begin
      check($sformatf("read at %h", adr_q.pop_front()), exp_q.pop_front(), reg_rdata);
    end else if (srst === 1'b0) begin
      check("idle read data", 16'h0000, reg_rdata);
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("wrong value cycle limit expected below 5000 seen %0d", cycles);
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hc059;
    {srst, reg_write, reg_read} = 3'b100;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    {cell_voltage_reading, thermal_reading} = {16'ha000, 16'h1400};
    {reported_charge_percent, current_reading} = {16'h3200, 16'h0000};
    normal_output_words = {$random(seed), $random(seed), $random(seed), $random(seed)};
    lim_adr = '{ADDR_VOLTAGE_LIMITS, ADDR_THERMAL_LIMITS, ADDR_CHARGE_LIMITS, ADDR_CURRENT_LIMITS};
    up = '{8'hc0, 8'h28, 8'h50, 8'h10};
    lo = '{8'h80, 8'hf6, 8'h14, 8'hf0};
    mid = '{16'ha000, 16'h1400, 16'h3200, 16'h0000};
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    // Reset values, then back-to-back reads with no gap.
    rd(ADDR_VOLTAGE_LIMITS, 16'hff00);
    rd(ADDR_THERMAL_LIMITS, 16'h7f80);
    rd(ADDR_CHARGE_LIMITS, 16'hff00);
    rd(ADDR_CURRENT_LIMITS, 16'h7f80);
    rd(ADDR_SECONDARY_CONFIG, 16'h3000);
    idle(1);
    pin(1'b1);
    check("enables after reset", 16'h0003, {14'h0000, rate_estimate_enable, dynamic_power_enable});
    // Disabled limits never trip, whatever the readings are.
    repeat (8) begin
      set_rd(16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
      idle(3);
      rd(ADDR_ALERT_STATUS, 16'h0000);
    end
    // Writes outside the occupied pages land nowhere and never alias the voltage, thermal or
    // charge limit word.
    foreach (rv[k]) begin
      wr(k[0] ? 8'h51 : (k[1] ? 8'hc3 : 8'he2), 16'hffff);
      rd(k[0] ? 8'h51 : (k[1] ? 8'hc3 : 8'he2), 16'h0000);
    end
    rd(ADDR_VOLTAGE_LIMITS, 16'hff00);
    rd(ADDR_THERMAL_LIMITS, 16'h7f80);
    rd(ADDR_CHARGE_LIMITS, 16'hff00);
    // Limit words round-trip, then take the comparison limits.
    for (int c = 0; c < 4; c++) begin
      rv[c] = 16'($random(seed));
      wr(lim_adr[c], rv[c]);
      rd(lim_adr[c], rv[c]);
      wr(lim_adr[c], {up[c], lo[c]});
    end
    set_rd(mid[0], mid[1], mid[2], mid[3]);
    // Above, at, below and at each bound; the pin stays off while disabled.
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        logic [7:0] b;
        b = (k == 0) ? up[c] + 8'h01 : (k == 1) ? up[c] : (k == 2) ? lo[c] - 8'h01 : lo[c];
        rv = mid;
        rv[c] = (c == 3) ? 16'($signed(b)) <<< 9 : {b, (k[0] ? 8'h00 : 8'($random(seed)))};
        set_rd(rv[0], rv[1], rv[2], rv[3]);
        idle(3);
        rd(ADDR_ALERT_STATUS, k[0] ? 16'h0000 : 16'h0001 << (2 * c + (k == 0)));
        idle(1);
        pin(1'b1);
      end
    end
    // Enabled, self-clearing: the pin follows the violation.
    wr(ADDR_ALERT_CONTROL, 16'h0004);
    set_rd(mid[0], 16'hf500, mid[2], mid[3]);
    idle(3);
    pin(1'b0);
    set_rd(mid[0], mid[1], mid[2], mid[3]);
    idle(3);
    pin(1'b1);
    // Software-clear mode holds the flag and pin until written off.
    wr(ADDR_ALERT_CONTROL, 16'h0804);
    set_rd(16'hc100, mid[1], mid[2], mid[3]);
    idle(3);
    set_rd(mid[0], mid[1], mid[2], mid[3]);
    idle(3);
    rd(ADDR_ALERT_STATUS, 16'h0002);
    idle(1);
    pin(1'b0);
    wr(ADDR_ALERT_STATUS, 16'h0002);
    idle(3);
    rd(ADDR_ALERT_STATUS, 16'h0000);
    idle(1);
    pin(1'b1);
    // Normal words with both enables set, or with only one cleared.
    for (int i = 0; i < SERIAL_WORDS; i++) rd(SERIAL_ADDR[i], normal_output_words[16 * i +: 16]);
    wr(ADDR_SECONDARY_CONFIG, 16'h1000);
    rd(SERIAL_ADDR[3], normal_output_words[63:48]);
    // Both cleared: serial words, steady while the normal words move.
    wr(ADDR_SECONDARY_CONFIG, 16'h0000);
    wr(SERIAL_ADDR[0], 16'hffff);
    idle(1);
    @(negedge clock);
    check("enables", 16'h0000, {14'h0000, rate_estimate_enable, dynamic_power_enable});
    for (int i = 0; i < SERIAL_WORDS; i++) begin
      rd(SERIAL_ADDR[i], SER[16 * i +: 16]);
      normal_output_words <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    end
    wr(ADDR_SECONDARY_CONFIG, 16'h3000);
    rd(SERIAL_ADDR[7], normal_output_words[127:112]);
    idle(4);
    finish_test();
  end
endmodule : threshold_alert_regs_test
